/* File: pmx_pkg.sv */
// Constants, types and register map for the programmable function pin mux
// Function
// - Strap resistor picks mode: 200k pull-up role swap, 10k pull-down speed indicators.
// - Role swap: pins 1,2 host kinds, 3 inverted swap, 4-5 SMBus, 6 request, 7 swap.
// - Port 0 host kind: float no host, 0 for 5 Gbps host, 1 for USB 2.0/1.1.
// - Port 1 host kind uses the same three-state encoding.
// - USB 2.0 host detected when its hub address register is non-zero and the 5 Gbps one is zero.
// - 5 Gbps host detected when its hub address register is non-zero.
// - Swap request input: 0 normal roles, 1 swapped; driven by the outside party.
// - Swap state output follows the swap request: 0 normal, 1 swapped.
// - Inverted swap state output is always the complement of the swap request.
// - Speed mode: pins 1-3 speed ports 1-3, 4-5 SMBus, 6 port 4, 7 host kind.
// - Speed indicator floats unconnected, 0 for USB 2.0/1.1, 1 for 5 Gbps.
// - Pins 4 and 5 carry SMBus data and clock in both modes.
package pmx_pkg;
   // Strap resistor codes, in order of the strap table
   typedef enum logic [2:0] {
      pmx_strap_200k_down = 3'h0,
      pmx_strap_200k_up   = 3'h1,
      pmx_strap_10k_down  = 3'h2,
      pmx_strap_10k_up    = 3'h3,
      pmx_strap_10r_down  = 3'h4,
      pmx_strap_10r_up    = 3'h5
   } pmx_strap_type;

   // Pin modes this block implements
   typedef enum logic [1:0] {
      pmx_mode_off   = 2'h0,
      pmx_mode_swap  = 2'h1,
      pmx_mode_speed = 2'h2
   } pmx_mode_type;

   // Pin positions on the programmable function bus
   localparam int PIN_LOW     = 1;
   localparam int PIN_HIGH    = 7;
   localparam int PIN_HOST0   = 1;
   localparam int PIN_HOST1   = 2;
   localparam int PIN_SWAP_N  = 3;
   localparam int PIN_SMDATA  = 4;
   localparam int PIN_SMCLOCK = 5;
   localparam int PIN_REQUEST = 6;
   localparam int PIN_SWAP    = 7;
   localparam int PIN_SPEED4  = 6;
   localparam int PIN_HOSTSPD = 7;

   // Register byte offsets
   localparam logic [7:0] REG_STATUS    = 8'h00;
   localparam logic [7:0] REG_P0_HS_ADR = 8'h04;
   localparam logic [7:0] REG_P0_SS_ADR = 8'h08;
   localparam logic [7:0] REG_P1_HS_ADR = 8'h0c;
   localparam logic [7:0] REG_P1_SS_ADR = 8'h10;
   localparam logic [7:0] REG_DN_LINK   = 8'h14;
   localparam logic [7:0] REG_PIN_STATE = 8'h18;

   // Field layout and reset values
   localparam int          ADDR_W       = 7;
   localparam int          DN_PORTS     = 4;
   localparam logic [6:0]  ADDR_RESET   = 7'h00;
   localparam logic [7:0]  DN_RESET     = 8'h00;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage

/* File: pmx_host_kind.sv */
// Three-state host kind encoder from the two hub address registers
`timescale 1ns/100ps
module pmx_host_kind #(
   parameter int ADDR_W = 7
) (
   input  wire logic [ADDR_W-1:0] hs_addr,
   input  wire logic [ADDR_W-1:0] ss_addr,
   output logic                   drive,
   output logic                   level
);
   // A 5 Gbps address wins when both are set, since the faster link is in use
   always_comb begin
      drive = 1'b0;
      level = 1'b0;
      if (ss_addr != '0) begin
         drive = 1'b1;
         level = 1'b0;
      end else if (hs_addr != '0) begin
         drive = 1'b1;
         level = 1'b1;
      end
   end
endmodule // pmx_host_kind

/* File: pmx_speed_ind.sv */
// Three-state speed indicator encoder for one downstream port
`timescale 1ns/100ps
module pmx_speed_ind (
   input  wire logic connected,
   input  wire logic super_speed,
   output logic      drive,
   output logic      level
);
   // Float while unconnected so the LED stays dark
   always_comb begin
      drive = connected;
      level = connected & super_speed;
   end
endmodule // pmx_speed_ind

/* File: pmx_pin_mux.sv */
// Programmable function pin mux with AHB-Lite status and address registers
`timescale 1ns/100ps
module pmx_pin_mux #(
   parameter int ADDR_W   = pmx_pkg::ADDR_W,
   parameter int DN_PORTS = pmx_pkg::DN_PORTS
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // Strap and serial block connections
   input  wire logic [2:0]  strap_code,
   input  wire logic [1:0]  serial_interface_select,
   input  wire logic        smbus_data_drive_low,
   input  wire logic        smbus_clock_drive_low,
   output logic             smbus_data_in,
   output logic             smbus_clock_in,
   output logic [1:0]       smbus_bridge_mode,
   output logic             role_swap_state,
   // Pins
   input  wire logic [7:1]  programmable_function_pin_in,
   output logic [7:1]       programmable_function_pin_out,
   output logic [7:1]       programmable_function_pin_oe,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp
);
   pmx_pkg::pmx_mode_type mode;
   logic                  mode_valid;
   logic                  swap_req;
   logic [ADDR_W-1:0]     p0_hs_addr;
   logic [ADDR_W-1:0]     p0_ss_addr;
   logic [ADDR_W-1:0]     p1_hs_addr;
   logic [ADDR_W-1:0]     p1_ss_addr;
   logic [2*DN_PORTS-1:0] dn_link;
   logic                  p0_drive;
   logic                  p0_level;
   logic                  p1_drive;
   logic                  p1_level;
   logic [DN_PORTS-1:0]   spd_drive;
   logic [DN_PORTS-1:0]   spd_level;
   logic [7:1]            next_pin_out;
   logic [7:1]            next_pin_oe;
   logic                  dp_write;
   logic                  dp_read;
   logic [7:0]            dp_addr;
   logic [31:0]           next_rdata;

   // Strap code to pin mode; unsupported straps leave every pin floating
   function automatic pmx_pkg::pmx_mode_type strap_to_mode(input logic [2:0] code);
      case (code)
         pmx_pkg::pmx_strap_200k_up:  strap_to_mode = pmx_pkg::pmx_mode_swap;
         pmx_pkg::pmx_strap_10k_down: strap_to_mode = pmx_pkg::pmx_mode_speed;
         default:                     strap_to_mode = pmx_pkg::pmx_mode_off;
      endcase
   endfunction

   // Register byte offset match, used by the register write decode
   function automatic logic offset_is(input logic [7:0] a, input logic [7:0] off);
      offset_is = (a == off);
   endfunction

   // Strap caught once, at the first enabled edge after reset release
   always_ff @(posedge clk) begin
      if (rst) begin
         mode       <= pmx_pkg::pmx_mode_off;
         mode_valid <= 1'b0;
      end else if (ce && !mode_valid) begin
         mode       <= strap_to_mode(strap_code);
         mode_valid <= 1'b1;
      end
   end

   // Swap request pin sampled; only meaningful in role swap mode
   always_ff @(posedge clk) begin
      if (rst) begin
         swap_req <= 1'b0;
      end else if (ce) begin
         swap_req <= programmable_function_pin_in[pmx_pkg::PIN_REQUEST];
      end
   end

   // Host kind and speed encoders
   pmx_host_kind #(
      .ADDR_W (ADDR_W)
   ) u_host0 (
      .hs_addr (p0_hs_addr),
      .ss_addr (p0_ss_addr),
      .drive   (p0_drive),
      .level   (p0_level)
   );

   pmx_host_kind #(
      .ADDR_W (ADDR_W)
   ) u_host1 (
      .hs_addr (p1_hs_addr),
      .ss_addr (p1_ss_addr),
      .drive   (p1_drive),
      .level   (p1_level)
   );

   genvar gi;
   generate
      for (gi = 0; gi < DN_PORTS; gi++) begin : g_speed
         pmx_speed_ind u_speed (
            .connected   (dn_link[2*gi]),
            .super_speed (dn_link[2*gi+1]),
            .drive       (spd_drive[gi]),
            .level       (spd_level[gi])
         );
      end
   endgenerate

   // Pin assignment per latched mode
   always_comb begin
      next_pin_out = '0;
      next_pin_oe  = '0;
      // SMBus pins are open drain: enable only to pull low
      if (mode != pmx_pkg::pmx_mode_off) begin
         next_pin_oe[pmx_pkg::PIN_SMDATA]  = smbus_data_drive_low;
         next_pin_oe[pmx_pkg::PIN_SMCLOCK] = smbus_clock_drive_low;
      end
      case (mode)
         pmx_pkg::pmx_mode_swap: begin
            next_pin_oe[pmx_pkg::PIN_HOST0]   = p0_drive;
            next_pin_out[pmx_pkg::PIN_HOST0]  = p0_level;
            next_pin_oe[pmx_pkg::PIN_HOST1]   = p1_drive;
            next_pin_out[pmx_pkg::PIN_HOST1]  = p1_level;
            next_pin_oe[pmx_pkg::PIN_SWAP_N]  = 1'b1;
            next_pin_out[pmx_pkg::PIN_SWAP_N] = ~swap_req;
            next_pin_oe[pmx_pkg::PIN_SWAP]    = 1'b1;
            next_pin_out[pmx_pkg::PIN_SWAP]   = swap_req;
         end
         pmx_pkg::pmx_mode_speed: begin
            next_pin_oe[3:1]                   = spd_drive[2:0];
            next_pin_out[3:1]                  = spd_level[2:0];
            next_pin_oe[pmx_pkg::PIN_SPEED4]   = spd_drive[3];
            next_pin_out[pmx_pkg::PIN_SPEED4]  = spd_level[3];
            next_pin_oe[pmx_pkg::PIN_HOSTSPD]  = p0_drive;
            next_pin_out[pmx_pkg::PIN_HOSTSPD] = p0_level;
         end
         default: begin
            next_pin_out = '0;
            next_pin_oe  = '0;
         end
      endcase
   end

   // Pin drivers straight from flops
   always_ff @(posedge clk) begin
      if (rst) begin
         programmable_function_pin_out <= '0;
         programmable_function_pin_oe  <= '0;
      end else if (ce) begin
         programmable_function_pin_out <= next_pin_out;
         programmable_function_pin_oe  <= next_pin_oe;
      end
   end

   // SMBus returns and side outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         smbus_data_in     <= 1'b1;
         smbus_clock_in    <= 1'b1;
         smbus_bridge_mode <= 2'h0;
         role_swap_state   <= 1'b0;
      end else if (ce) begin
         smbus_data_in     <= programmable_function_pin_in[pmx_pkg::PIN_SMDATA];
         smbus_clock_in    <= programmable_function_pin_in[pmx_pkg::PIN_SMCLOCK];
         smbus_bridge_mode <= serial_interface_select;
         role_swap_state   <= (mode == pmx_pkg::pmx_mode_swap) & swap_req;
      end
   end

   // AHB address phase capture; reads take one wait state
   always_ff @(posedge clk) begin
      if (rst) begin
         dp_write <= 1'b0;
         dp_read  <= 1'b0;
         dp_addr  <= 8'h00;
      end else if (ce && hready) begin
         dp_write <= hsel && htrans == pmx_pkg::HTRANS_NONSEQ && hwrite;
         dp_read  <= hsel && htrans == pmx_pkg::HTRANS_NONSEQ && !hwrite;
         dp_addr  <= haddr[7:0];
      end else if (ce) begin
         dp_read  <= 1'b0;
      end
   end

   // Wait-state tracking: low for the first read data cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
      end else if (ce) begin
         hreadyout  <= !(hready && hsel && htrans == pmx_pkg::HTRANS_NONSEQ && !hwrite);
         hresp      <= 1'b0;
      end
   end

   // Software writable registers; the hub core view of addresses and links
   always_ff @(posedge clk) begin
      if (rst) begin
         p0_hs_addr <= pmx_pkg::ADDR_RESET;
         p0_ss_addr <= pmx_pkg::ADDR_RESET;
         p1_hs_addr <= pmx_pkg::ADDR_RESET;
         p1_ss_addr <= pmx_pkg::ADDR_RESET;
         dn_link    <= pmx_pkg::DN_RESET;
      end else if (ce && dp_write) begin
         if (offset_is(dp_addr, pmx_pkg::REG_P0_HS_ADR)) begin
            p0_hs_addr <= hwdata[ADDR_W-1:0];
         end
         if (offset_is(dp_addr, pmx_pkg::REG_P0_SS_ADR)) begin
            p0_ss_addr <= hwdata[ADDR_W-1:0];
         end
         if (offset_is(dp_addr, pmx_pkg::REG_P1_HS_ADR)) begin
            p1_hs_addr <= hwdata[ADDR_W-1:0];
         end
         if (offset_is(dp_addr, pmx_pkg::REG_P1_SS_ADR)) begin
            p1_ss_addr <= hwdata[ADDR_W-1:0];
         end
         if (offset_is(dp_addr, pmx_pkg::REG_DN_LINK)) begin
            dn_link <= hwdata[2*DN_PORTS-1:0];
         end
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (dp_addr)
         pmx_pkg::REG_STATUS:    next_rdata = {27'h0, mode_valid, swap_req, 1'b0, mode};
         pmx_pkg::REG_P0_HS_ADR: next_rdata = {{(32-ADDR_W){1'b0}}, p0_hs_addr};
         pmx_pkg::REG_P0_SS_ADR: next_rdata = {{(32-ADDR_W){1'b0}}, p0_ss_addr};
         pmx_pkg::REG_P1_HS_ADR: next_rdata = {{(32-ADDR_W){1'b0}}, p1_hs_addr};
         pmx_pkg::REG_P1_SS_ADR: next_rdata = {{(32-ADDR_W){1'b0}}, p1_ss_addr};
         pmx_pkg::REG_DN_LINK:   next_rdata = {{(32-2*DN_PORTS){1'b0}}, dn_link};
         pmx_pkg::REG_PIN_STATE: next_rdata = {17'h0, programmable_function_pin_oe,
                                               1'b0, programmable_function_pin_out};
         default:                next_rdata = 32'h0000_0000;
      endcase
   end

   // Read data registered in the wait cycle, after any write just before
   always_ff @(posedge clk) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (ce && dp_read) begin
         hrdata <= next_rdata;
      end
   end

   // Checks on the mode latch, pin behaviour and read wait state
   property p_mode_held;
      @(posedge clk) disable iff (rst)
      mode_valid && $past(mode_valid) |-> mode == $past(mode);
   endproperty
   a_mode_held: assert property (p_mode_held)
      else $error("pin mode changed after latching");

   property p_strap_decode;
      @(posedge clk) disable iff (rst)
      $rose(mode_valid) |->
         (mode == pmx_pkg::pmx_mode_swap) == ($past(strap_code) == 3'h1) &&
         (mode == pmx_pkg::pmx_mode_speed) == ($past(strap_code) == 3'h2);
   endproperty
   a_strap_decode: assert property (p_strap_decode)
      else $error("strap decoded to wrong mode");

   property p_swap_follows;
      @(posedge clk) disable iff (rst)
      ce && $past(ce) && $past(ce, 2) && mode == pmx_pkg::pmx_mode_swap && $past(mode_valid)
         |-> programmable_function_pin_out[7] == $past(programmable_function_pin_in[6], 2)
             && programmable_function_pin_oe[7];
   endproperty
   a_swap_follows: assert property (p_swap_follows)
      else $error("swap state pin does not follow request");

   property p_swap_inverse;
      @(posedge clk) disable iff (rst)
      programmable_function_pin_oe[7] && mode == pmx_pkg::pmx_mode_swap
         |-> programmable_function_pin_oe[3] &&
             programmable_function_pin_out[3] != programmable_function_pin_out[7];
   endproperty
   a_swap_inverse: assert property (p_swap_inverse)
      else $error("inverted swap pin not complementary");

   property p_request_input;
      @(posedge clk) disable iff (rst)
      mode == pmx_pkg::pmx_mode_swap |-> !programmable_function_pin_oe[6];
   endproperty
   a_request_input: assert property (p_request_input)
      else $error("swap request pin driven");

   property p_smbus_open_drain;
      @(posedge clk) disable iff (rst)
      programmable_function_pin_oe[4] || programmable_function_pin_oe[5]
         |-> programmable_function_pin_out[5:4] == 2'h0 && $past(mode) != pmx_pkg::pmx_mode_off;
   endproperty
   a_smbus_open_drain: assert property (p_smbus_open_drain)
      else $error("SMBus pin driven high or in off mode");

   property p_host_float;
      @(posedge clk) disable iff (rst)
      ce && $past(ce) && $past(mode) == pmx_pkg::pmx_mode_swap &&
      $past(p0_hs_addr) == '0 && $past(p0_ss_addr) == '0 |-> !programmable_function_pin_oe[1];
   endproperty
   a_host_float: assert property (p_host_float)
      else $error("host kind driven with no host");

   property p_host_ss;
      @(posedge clk) disable iff (rst)
      ce && $past(ce) && $past(mode) == pmx_pkg::pmx_mode_swap && $past(p1_ss_addr) != '0
         |-> programmable_function_pin_oe[2] && !programmable_function_pin_out[2];
   endproperty
   a_host_ss: assert property (p_host_ss)
      else $error("5 Gbps host not shown as 0");

   property p_host_hs;
      @(posedge clk) disable iff (rst)
      ce && $past(ce) && $past(mode) == pmx_pkg::pmx_mode_swap &&
      $past(p0_ss_addr) == '0 && $past(p0_hs_addr) != '0
         |-> programmable_function_pin_oe[1] && programmable_function_pin_out[1];
   endproperty
   a_host_hs: assert property (p_host_hs)
      else $error("USB 2.0 host not shown as 1");

   property p_speed_ind;
      @(posedge clk) disable iff (rst)
      ce && $past(ce) && $past(mode) == pmx_pkg::pmx_mode_speed
         |-> programmable_function_pin_oe[1] == $past(dn_link[0]) &&
             programmable_function_pin_oe[6] == $past(dn_link[6]) &&
             programmable_function_pin_out[6] == ($past(dn_link[6]) && $past(dn_link[7]));
   endproperty
   a_speed_ind: assert property (p_speed_ind)
      else $error("speed indicator wrong");

   property p_speed_host;
      @(posedge clk) disable iff (rst)
      ce && $past(ce) && $past(mode) == pmx_pkg::pmx_mode_speed
         |-> programmable_function_pin_oe[7] == ($past(p0_ss_addr) != '0 ||
                                                 $past(p0_hs_addr) != '0);
   endproperty
   a_speed_host: assert property (p_speed_host)
      else $error("host kind pin wrong in speed mode");

   property p_read_wait;
      @(posedge clk) disable iff (rst)
      ce && hready && hsel && htrans == 2'h2 && !hwrite |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait)
      else $error("read wait state wrong");
endmodule // pmx_pin_mux

/* File: pmx_board_model.sv */
// Board side model: status LEDs, swap request driver and SMBus pull-ups
`timescale 1ns/100ps
module pmx_board_model (
   input  wire logic       clk,
   input  wire logic [7:1] pin_out,
   input  wire logic [7:1] pin_oe,
   input  wire logic       request_en,
   input  wire logic       swap_cmd,
   input  wire logic       ext_data_low,
   input  wire logic       ext_clock_low,
   output logic [7:1]      pin_level
);
   logic flip = 1'b0;

   // Released pins wander, so a stale level never passes as driven
   always @(posedge clk) begin
      flip <= ~flip;
   end

   // Wire level seen by every party on each pin
   always_comb begin
      for (int i = 1; i <= 7; i++) begin
         pin_level[i] = pin_oe[i] ? pin_out[i] : flip;
      end
      pin_level[6] = pin_oe[6] ? pin_out[6] : (request_en ? swap_cmd : flip);
      // Open drain with pull-up: either side may pull low
      pin_level[4] = ~(pin_oe[4] & ~pin_out[4]) & ~ext_data_low;
      pin_level[5] = ~(pin_oe[5] & ~pin_out[5]) & ~ext_clock_low;
   end
endmodule // pmx_board_model

/* File: tb_top.sv */
// Self-checking testbench for the programmable function pin mux
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %s exp=%h got=%h", n, e, g); end end
module tb_top;
   logic        clk;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic [2:0]  strap_code = 3'h1;
   logic [1:0]  ssel = 2'h0;
   logic        dl = 1'b0;
   logic        cl = 1'b0;
   logic        ext_dl = 1'b0;
   logic        ext_cl = 1'b0;
   logic        req_en = 1'b0;
   logic        swap_cmd = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        smbus_data_in;
   logic        smbus_clock_in;
   logic [1:0]  smbus_bridge_mode;
   logic        role_swap_state;
   logic [7:1]  pin_out;
   logic [7:1]  pin_oe;
   logic [7:1]  pin_level;
   logic [31:0] regm [0:6];
   pmx_pkg::pmx_mode_type mode_q;
   int          n_fail = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          seed = 32'h1f72;

   pmx_pin_mux i_pmx_pin_mux (.clk(clk), .rst(rst), .ce(ce), .strap_code(strap_code),
      .serial_interface_select(ssel), .smbus_data_drive_low(dl),
      .smbus_clock_drive_low(cl), .smbus_data_in(smbus_data_in),
      .smbus_clock_in(smbus_clock_in), .smbus_bridge_mode(smbus_bridge_mode),
      .role_swap_state(role_swap_state), .programmable_function_pin_in(pin_level),
      .programmable_function_pin_out(pin_out), .programmable_function_pin_oe(pin_oe),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp));

   pmx_board_model i_pmx_board_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .request_en(req_en), .swap_cmd(swap_cmd), .ext_data_low(ext_dl),
      .ext_clock_low(ext_cl), .pin_level(pin_level));

   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Host kind as {drive, level}; 5 Gbps address wins over USB 2.0
   function automatic logic [1:0] host(logic [6:0] hs, logic [6:0] ss);
      if (ss != 7'h0) return 2'b10;
      if (hs != 7'h0) return 2'b11;
      return 2'b00;
   endfunction

   // Speed indicator from {super speed, connected}
   function automatic logic [1:0] spd(logic [1:0] l);
      return l[0] ? {1'b1, l[1]} : 2'b00;
   endfunction

   // Expected {oe[7:1], out[7:1]} for the latched mode
   function automatic logic [13:0] exp_pins();
      logic [7:1] oe;
      logic [7:1] o;
      logic [1:0] h0;
      oe = 7'h0;
      o = 7'h0;
      h0 = host(regm[1][6:0], regm[2][6:0]);
      if (mode_q != pmx_pkg::pmx_mode_off) begin
         oe[4] = dl;
         oe[5] = cl;
      end
      if (mode_q == pmx_pkg::pmx_mode_swap) begin
         {oe[1], o[1]} = h0;
         {oe[2], o[2]} = host(regm[3][6:0], regm[4][6:0]);
         {oe[3], o[3]} = {1'b1, ~swap_cmd};
         {oe[7], o[7]} = {1'b1, swap_cmd};
      end
      if (mode_q == pmx_pkg::pmx_mode_speed) begin
         for (int p = 1; p <= 3; p++) {oe[p], o[p]} = spd(regm[5][2*p-2 +: 2]);
         {oe[6], o[6]} = spd(regm[5][7:6]);
         {oe[7], o[7]} = h0;
      end
      return {oe, o};
   endfunction

   // One AHB-Lite single transfer; waits on hready in both phases
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= pmx_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      `CHK("hresp", 1'b0, hresp)
   endtask

   // Reset with a strap code; strap is held steady through release
   task automatic start(input logic [2:0] code);
      rst <= 1'b1;
      strap_code <= code;
      repeat (20) @(posedge clk);
      #1 `CHK("reset pins", 14'h0, {pin_oe, pin_out})
      `CHK("reset ready", 1'b1, hreadyout)
      @(posedge clk);
      rst <= 1'b0;
      req_en <= (code == 3'h1);
      mode_q = pmx_pkg::pmx_mode_type'(code == 3'h1 ? pmx_pkg::pmx_mode_swap :
               code == 3'h2 ? pmx_pkg::pmx_mode_speed : pmx_pkg::pmx_mode_off);
      for (int i = 0; i <= 6; i++) regm[i] = 32'h0;
      repeat (3) @(posedge clk);
   endtask

   // Random addresses, link states and pin levels, then all outputs checked
   task automatic round();
      logic [31:0] v;
      logic [31:0] r;
      logic [13:0] ep;
      int k;
      for (int i = 1; i <= 5; i++) begin
         k = $random(seed) & 3;
         v = k == 0 ? 32'h0 : k == 1 ? 32'hffffff80 : k == 2 ? 32'h1 : $random(seed);
         ahb(1'b1, 8'(i * 4), v, r);
         regm[i] = v & (i == 5 ? 32'hff : 32'h7f);
      end
      for (int i = 1; i <= 5; i++) begin
         ahb(1'b0, 8'(i * 4), 32'h0, r);
         `CHK("addr reg", regm[i], r)
      end
      swap_cmd <= 1'($random(seed));
      dl <= 1'($random(seed));
      cl <= 1'($random(seed));
      ext_dl <= 1'($random(seed));
      ext_cl <= 1'($random(seed));
      ssel <= 2'($random(seed));
      repeat (5) @(posedge clk);
      #1 ep = exp_pins();
      `CHK("pins", ep, {pin_oe, pin_out})
      `CHK("swap state", mode_q == pmx_pkg::pmx_mode_swap && swap_cmd, role_swap_state)
      `CHK("smb data", ~(ext_dl | (dl && mode_q != 0)), smbus_data_in)
      `CHK("smb clock", ~(ext_cl | (cl && mode_q != 0)), smbus_clock_in)
      `CHK("bridge", ssel, smbus_bridge_mode)
      ahb(1'b0, pmx_pkg::REG_PIN_STATE, 32'h0, r);
      `CHK("pin state", {17'h0, ep[13:7], 1'b0, ep[6:0]}, r)
      ahb(1'b0, pmx_pkg::REG_STATUS, 32'h0, r);
      // Request bit only means something in role swap mode
      if (mode_q != pmx_pkg::pmx_mode_swap) r[3] = 1'b0;
      `CHK("status", {27'h1, mode_q == 1 && swap_cmd, 1'b0, mode_q}, r)
   endtask

   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         conclude();
      end
   end

   task automatic conclude();
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Every strap code in turn from 0 to 5; unmapped and read-only places under code 0
   initial begin
      logic [31:0] r;
      for (int c = 0; c < 6; c++) begin
         start(3'(c));
         // Corner case: no host and no link straight after reset, so indicators float
         #1 `CHK("idle pins", exp_pins(), {pin_oe, pin_out})
         if (c == 0) begin
            ahb(1'b1, 8'h1c, 32'hffffffff, r);
            ahb(1'b0, 8'h1c, 32'h0, r);
            `CHK("unmapped", 32'h0, r)
            ahb(1'b1, pmx_pkg::REG_STATUS, 32'hffffffff, r);
            ahb(1'b1, pmx_pkg::REG_PIN_STATE, 32'hffffffff, r);
         end
         repeat (c == 1 || c == 2 ? 15 : 2) round();
         // Strap moves without a reset: mode must hold
         if (c == 1) begin
            strap_code <= 3'h2;
            repeat (3) round();
            // Clock enable low: pins hold although request and pull-down move
            r = {18'h0, pin_oe, pin_out};
            ce <= 1'b0;
            swap_cmd <= ~swap_cmd;
            dl <= ~dl;
            repeat (4) @(posedge clk);
            #1 `CHK("frozen pins", r[13:0], {pin_oe, pin_out})
            @(posedge clk);
            ce <= 1'b1;
         end
      end
      conclude();
   end
endmodule // tb_top
